// file: rtl/dbgevt_pkg.sv
// Package for the debug event detect unit: constants and types
package dbgevt_pkg;
    // Status flag positions
    localparam int ST_INSN = 0;
    localparam int ST_BRANCH = 1;
    localparam int ST_FAULT = 2;
    localparam int ST_TRAP = 3;
    localparam int ST_UNCOND = 4;
    localparam int ST_IA1 = 5;
    localparam int ST_IA2 = 6;
    localparam int ST_DR1 = 7;
    localparam int ST_DW1 = 8;
    localparam int ST_DR2 = 9;
    localparam int ST_DW2 = 10;
    localparam int ST_IMPRECISE = 11;
    localparam int ST_IA3 = 12;
    localparam int ST_IA4 = 13;
    localparam int ST_WIDTH = 14;
    localparam logic [ST_WIDTH-1:0] ST_RESET = 14'h0000;
    // Data compare size encodings
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] SZ_LINE = 2'h3;
    // Data value compare modes
    localparam logic [1:0] VM_AND = 2'h1;
    localparam logic [1:0] VM_OR = 2'h2;
    localparam logic [1:0] VM_ANDOR = 2'h3;

    typedef enum logic [2:0] {
        DBGEVT_RUN = 3'h1,
        DBGEVT_HALT = 3'h2,
        DBGEVT_WAIT = 3'h4
    } dbgevt_state_t;
endpackage

// file: rtl/dbgevt_unit.sv
// Debug event detect unit: event detection, status flags and debug actions
`timescale 1ns/1ps
module dbgevt_unit #(
    parameter int AW = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Debug modes
    input wire logic internal_dbg_mode,
    input wire logic external_dbg_mode,
    input wire logic wait_dbg_mode,
    input wire logic dbg_exc_allow,
    // Event enables
    input wire logic insn_done_evt_en,
    input wire logic branch_taken_evt_en,
    input wire logic exc_evt_en,
    input wire logic trap_evt_en,
    input wire logic [3:0] instr_match_en,
    input wire logic instr_range_lo_pair_en,
    input wire logic instr_range_hi_pair_en,
    input wire logic instr_range_lo_pair_toggle,
    input wire logic instr_range_hi_pair_toggle,
    input wire logic excl_load,
    input wire logic excl_lo_in,
    input wire logic excl_hi_in,
    // Instruction compare addresses, word aligned
    input wire logic [AW-1:0] instr_addr_compare_1,
    input wire logic [AW-1:0] instr_addr_compare_2,
    input wire logic [AW-1:0] instr_addr_compare_3,
    input wire logic [AW-1:0] instr_addr_compare_4,
    // Data compare configuration
    input wire logic data_cmp_first_read_en,
    input wire logic data_cmp_first_write_en,
    input wire logic data_cmp_second_read_en,
    input wire logic data_cmp_second_write_en,
    input wire logic [1:0] data_cmp_first_size,
    input wire logic [1:0] data_cmp_second_size,
    input wire logic data_range_en,
    input wire logic data_range_excl,
    input wire logic [AW-1:0] data_addr_compare_1,
    input wire logic [AW-1:0] data_addr_compare_2,
    input wire logic [1:0] value_cmp_first_mode,
    input wire logic [3:0] value_cmp_first_bytes,
    input wire logic [1:0] value_cmp_second_mode,
    input wire logic [3:0] value_cmp_second_bytes,
    input wire logic [31:0] data_value_compare_1,
    input wire logic [31:0] data_value_compare_2,
    // Pipeline events
    input wire logic insn_done,
    input wire logic branch_taken,
    input wire logic exc_noncrit,
    input wire logic exc_crit,
    input wire logic trap_hit,
    input wire logic uncond_req,
    input wire logic instr_valid,
    input wire logic [AW-1:0] instr_addr,
    input wire logic ls_valid,
    input wire logic ls_store,
    input wire logic [AW-1:0] effective_addr,
    input wire logic ls_data_valid,
    input wire logic [31:0] ls_data,
    input wire logic irq_any,
    // Status clear
    input wire logic status_clr,
    input wire logic [dbgevt_pkg::ST_WIDTH-1:0] status_clr_mask,
    // Outputs
    output logic [dbgevt_pkg::ST_WIDTH-1:0] debug_status,
    output logic dbg_irq,
    output logic core_halt,
    output logic trap_no_prog_exc,
    output logic instr_range_lo_pair_excl,
    output logic instr_range_hi_pair_excl
);
    import dbgevt_pkg::*;

    typedef struct packed {
        logic [ST_WIDTH-1:0] status;
        logic irq;
        logic halt;
        logic trap_block;
        logic excl_lo;
        logic excl_hi;
        dbgevt_state_t st;
        logic dv1_rd;
        logic dv1_wr;
        logic dv2_rd;
        logic dv2_wr;
    } dbgevt_regs_t;

    dbgevt_regs_t r;
    dbgevt_regs_t next_r;

    // Masked exact address compare
    function automatic logic dbgevt_addr_eq(input logic [AW-1:0] a, input logic [AW-1:0] b,
                                            input logic [1:0] sz);
        logic [AW-1:0] m;
        m = '1;
        case (sz)
            SZ_BYTE: m = '1;
            SZ_HALF: m[0] = 1'b0;
            SZ_WORD: m[1:0] = 2'h0;
            default: m[4:0] = 5'h00;
        endcase
        return ((a ^ b) & m) == '0;
    endfunction

    // Range check: inclusive lo<=a<hi, exclusive a<lo or a>=hi
    function automatic logic dbgevt_in_range(input logic [AW-1:0] a, input logic [AW-1:0] lo,
                                             input logic [AW-1:0] hi, input logic excl);
        if (excl) begin
            return (a < lo) || (a >= hi);
        end
        return (a >= lo) && (a < hi);
    endfunction

    function automatic logic dbgevt_value_eq(input logic [31:0] d, input logic [31:0] v,
                                             input logic [1:0] mode, input logic [3:0] be);
        logic [3:0] eq;
        logic [3:0] ok;
        for (int i = 0; i < 4; i++) begin
            eq[i] = d[i*8 +: 8] == v[i*8 +: 8];
        end
        ok = eq | ~be;
        case (mode)
            VM_AND: return &ok;
            VM_OR: return |(eq & be);
            VM_ANDOR: return (&ok[3:2] && |be[3:2]) || (&ok[1:0] && |be[1:0]);
            default: return 1'b0;
        endcase
    endfunction

    logic idm_only;
    logic idm_block;
    logic [AW-1:0] ia [4];
    logic [3:0] ia_hit;
    logic lo_rng;
    logic hi_rng;
    logic lo_rng_hit;
    logic hi_rng_hit;
    logic rd1_en;
    logic rd2_en;
    logic wr1_en;
    logic wr2_en;
    logic dac1;
    logic dac2;
    logic dv1_en;
    logic dv2_en;
    logic [ST_WIDTH-1:0] evt;
    logic any_evt;
    logic trap_active;

    always_comb begin
        idm_only = internal_dbg_mode && !external_dbg_mode;
        idm_block = idm_only && !dbg_exc_allow;
        ia[0] = instr_addr_compare_1;
        ia[1] = instr_addr_compare_2;
        ia[2] = instr_addr_compare_3;
        ia[3] = instr_addr_compare_4;
        lo_rng = instr_range_lo_pair_en && |instr_match_en[1:0]
                 && !(instr_range_lo_pair_toggle && idm_block);
        hi_rng = instr_range_hi_pair_en && |instr_match_en[3:2]
                 && !(instr_range_hi_pair_toggle && idm_block);
        lo_rng_hit = instr_valid && lo_rng && dbgevt_in_range(instr_addr, ia[0], ia[1], r.excl_lo);
        hi_rng_hit = instr_valid && hi_rng && dbgevt_in_range(instr_addr, ia[2], ia[3], r.excl_hi);
        for (int i = 0; i < 4; i++) begin
            ia_hit[i] = instr_valid && instr_match_en[i] && (instr_addr[AW-1:2] == ia[i][AW-1:2]);
        end
        // no exact compare in range mode, even while a toggle has the range disabled
        ia_hit[1:0] = instr_range_lo_pair_en ? ({2{lo_rng_hit}} & instr_match_en[1:0]) : ia_hit[1:0];
        ia_hit[3:2] = instr_range_hi_pair_en ? ({2{hi_rng_hit}} & instr_match_en[3:2]) : ia_hit[3:2];
        rd1_en = ls_valid && !ls_store && data_cmp_first_read_en;
        wr1_en = ls_valid && ls_store && data_cmp_first_write_en;
        rd2_en = ls_valid && !ls_store && data_cmp_second_read_en;
        wr2_en = ls_valid && ls_store && data_cmp_second_write_en;
        if (data_range_en) begin
            dac1 = dbgevt_in_range(effective_addr, data_addr_compare_1, data_addr_compare_2,
                                   data_range_excl);
            dac2 = dac1;
        end else begin
            dac1 = dbgevt_addr_eq(effective_addr, data_addr_compare_1, data_cmp_first_size);
            dac2 = dbgevt_addr_eq(effective_addr, data_addr_compare_2, data_cmp_second_size);
        end
        dv1_en = |value_cmp_first_bytes;
        dv2_en = |value_cmp_second_bytes;
        evt = '0;
        evt[ST_INSN] = insn_done && insn_done_evt_en && !idm_block;
        evt[ST_BRANCH] = branch_taken && branch_taken_evt_en && !idm_block;
        evt[ST_FAULT] = exc_evt_en && (exc_noncrit || (exc_crit && !idm_only));
        evt[ST_TRAP] = trap_hit && trap_evt_en;
        evt[ST_UNCOND] = uncond_req;
        evt[ST_IA1] = ia_hit[0];
        evt[ST_IA2] = ia_hit[1];
        evt[ST_IA3] = ia_hit[2];
        evt[ST_IA4] = ia_hit[3];
        // Value compare replaces the address event for that register
        evt[ST_DR1] = rd1_en && dac1 && !dv1_en;
        evt[ST_DW1] = wr1_en && dac1 && !dv1_en;
        evt[ST_DR2] = rd2_en && dac2 && !dv2_en;
        evt[ST_DW2] = wr2_en && dac2 && !dv2_en;
        if (ls_data_valid) begin
            evt[ST_DR1] = evt[ST_DR1] || (r.dv1_rd && dbgevt_value_eq(ls_data, data_value_compare_1,
                                          value_cmp_first_mode, value_cmp_first_bytes));
            evt[ST_DW1] = evt[ST_DW1] || (r.dv1_wr && dbgevt_value_eq(ls_data, data_value_compare_1,
                                          value_cmp_first_mode, value_cmp_first_bytes));
            evt[ST_DR2] = evt[ST_DR2] || (r.dv2_rd && dbgevt_value_eq(ls_data, data_value_compare_2,
                                          value_cmp_second_mode, value_cmp_second_bytes));
            evt[ST_DW2] = evt[ST_DW2] || (r.dv2_wr && dbgevt_value_eq(ls_data, data_value_compare_2,
                                          value_cmp_second_mode, value_cmp_second_bytes));
        end
        any_evt = |evt;
        evt[ST_IMPRECISE] = any_evt && !dbg_exc_allow;
        trap_active = external_dbg_mode || (internal_dbg_mode && dbg_exc_allow) || wait_dbg_mode;
    end

    always_comb begin
        next_r = r;
        next_r.dv1_rd = 1'b0;
        next_r.dv1_wr = 1'b0;
        next_r.dv2_rd = 1'b0;
        next_r.dv2_wr = 1'b0;
        if (ls_valid) begin
            next_r.dv1_rd = rd1_en && dac1 && dv1_en;
            next_r.dv1_wr = wr1_en && dac1 && dv1_en;
            next_r.dv2_rd = rd2_en && dac2 && dv2_en;
            next_r.dv2_wr = wr2_en && dac2 && dv2_en;
        end else if (!ls_data_valid) begin
            // Hold pending value compare until the data comes back
            next_r.dv1_rd = r.dv1_rd;
            next_r.dv1_wr = r.dv1_wr;
            next_r.dv2_rd = r.dv2_rd;
            next_r.dv2_wr = r.dv2_wr;
        end
        if (status_clr) begin
            next_r.status = r.status & ~status_clr_mask;
        end
        next_r.status = next_r.status | evt;
        next_r.trap_block = trap_hit && trap_evt_en && trap_active;
        if (excl_load) begin
            next_r.excl_lo = excl_lo_in;
            next_r.excl_hi = excl_hi_in;
        end
        if (instr_range_lo_pair_toggle && lo_rng_hit && |instr_match_en[1:0]) begin
            next_r.excl_lo = ~r.excl_lo;
        end
        if (instr_range_hi_pair_toggle && hi_rng_hit && |instr_match_en[3:2]) begin
            next_r.excl_hi = ~r.excl_hi;
        end
        if (internal_dbg_mode && any_evt && dbg_exc_allow) begin
            next_r.irq = 1'b1;
        end else if (!internal_dbg_mode) begin
            next_r.irq = 1'b0;
        end
        case (r.st)
            DBGEVT_RUN: begin
                if (any_evt && external_dbg_mode) begin
                    next_r.st = DBGEVT_HALT;
                    next_r.halt = 1'b1;
                end else if (any_evt && !internal_dbg_mode && wait_dbg_mode) begin
                    next_r.st = DBGEVT_WAIT;
                    next_r.halt = 1'b1;
                end
            end
            DBGEVT_HALT: begin
                // Debugger releases by dropping external mode
                if (!external_dbg_mode) begin
                    next_r.st = DBGEVT_RUN;
                    next_r.halt = 1'b0;
                end
            end
            DBGEVT_WAIT: begin
                if (irq_any) begin
                    next_r.st = DBGEVT_RUN;
                    next_r.halt = 1'b0;
                end
            end
            default: begin
                next_r.st = DBGEVT_RUN;
                next_r.halt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '{status: ST_RESET, st: DBGEVT_RUN, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign debug_status = r.status;
    assign dbg_irq = r.irq;
    assign core_halt = r.halt;
    assign trap_no_prog_exc = r.trap_block;
    assign instr_range_lo_pair_excl = r.excl_lo;
    assign instr_range_hi_pair_excl = r.excl_hi;

    a_uncond_flag: assert property (@(posedge clk) disable iff (rst)
        uncond_req |=> debug_status[ST_UNCOND]) else $error("uncond flag not set");
    a_ext_halt: assert property (@(posedge clk) disable iff (rst)
        (r.st == DBGEVT_RUN && any_evt && external_dbg_mode) |=> core_halt) else $error("no halt");
    a_int_irq: assert property (@(posedge clk) disable iff (rst)
        (internal_dbg_mode && dbg_exc_allow && any_evt) |=> dbg_irq) else $error("no irq");
    a_wait_resume: assert property (@(posedge clk) disable iff (rst)
        (r.st == DBGEVT_WAIT && irq_any) |=> !core_halt) else $error("wait not resumed");
    a_idle_nohalt: assert property (@(posedge clk) disable iff (rst)
        (!internal_dbg_mode && !external_dbg_mode && !wait_dbg_mode && r.st == DBGEVT_RUN)
        |=> !core_halt && !dbg_irq) else $error("action with no mode");
    a_insn_supp: assert property (@(posedge clk) disable iff (rst)
        (idm_block && insn_done && !debug_status[ST_INSN]) |=> !debug_status[ST_INSN])
        else $error("completion not suppressed");
    a_clear_mask: assert property (@(posedge clk) disable iff (rst)
        (status_clr && status_clr_mask[ST_BRANCH] && !evt[ST_BRANCH]) |=> !debug_status[ST_BRANCH])
        else $error("mask clear failed");
    a_imprecise: assert property (@(posedge clk) disable iff (rst)
        (any_evt && !dbg_exc_allow) |=> debug_status[ST_IMPRECISE]) else $error("imprecise lost");
    a_toggle_flip: assert property (@(posedge clk) disable iff (rst)
        (instr_range_lo_pair_toggle && lo_rng_hit && !excl_load) |=> (r.excl_lo != $past(r.excl_lo)))
        else $error("toggle missing");
    c_halt: cover property (@(posedge clk) disable iff (rst) r.st == DBGEVT_HALT);
    c_wait: cover property (@(posedge clk) disable iff (rst) r.st == DBGEVT_WAIT);
    c_range: cover property (@(posedge clk) disable iff (rst) lo_rng_hit);
    c_value: cover property (@(posedge clk) disable iff (rst) ls_data_valid && (r.dv1_rd || r.dv1_wr));
endmodule

// file: testbench/dbgevt_core_model.sv
// Stand-in for the core pipeline and the external debugger
`timescale 1ns/1ps
module dbgevt_core_model (
    // Clock and halt feedback
    input wire logic clk,
    input wire logic core_halt,
    // Pipeline pulses
    output logic insn_done,
    output logic branch_taken,
    output logic exc_noncrit,
    output logic exc_crit,
    output logic trap_hit,
    output logic irq_any,
    output logic uncond_req,
    // Fetch and load/store
    output logic instr_valid,
    output logic [31:0] instr_addr,
    output logic ls_valid,
    output logic ls_store,
    output logic [31:0] effective_addr,
    output logic ls_data_valid,
    output logic [31:0] ls_data
);
    initial begin
        {insn_done, branch_taken, exc_noncrit, exc_crit, trap_hit, irq_any, uncond_req} = '0;
        {instr_valid, ls_valid, ls_store, ls_data_valid} = '0;
        instr_addr = 32'h5A5A5A5A;
        effective_addr = 32'hA5A5A5A5;
        ls_data = 32'h3C3C3C3C;
    end

    // Kinds 0 done, 1 branch, 2 fault, 3 critical, 4 trap, 5 debugger, 6 fetch, 7 access, 8 irq
    task automatic issue(input logic [3:0] k, input logic [31:0] a, input logic st, input logic [31:0] d);
        logic run;
        @(posedge clk);
        #1;
        // Halted core issues nothing but the debugger (5) and irq (8) kinds
        run = !core_halt;
        insn_done = k == 4'h0 && run;
        branch_taken = k == 4'h1 && run;
        exc_noncrit = k == 4'h2 && run;
        exc_crit = k == 4'h3 && run;
        trap_hit = k == 4'h4 && run;
        uncond_req = k == 4'h5;
        instr_valid = k == 4'h6 && run;
        ls_valid = k == 4'h7 && run;
        irq_any = k == 4'h8;
        instr_addr = a;
        effective_addr = a;
        ls_store = st;
        @(posedge clk);
        #1;
        {insn_done, branch_taken, exc_noncrit, exc_crit, trap_hit, irq_any, uncond_req, instr_valid} = '0;
        // Released lines invert so stale values never pass
        instr_addr = ~a;
        effective_addr = ~a;
        ls_data_valid = ls_valid;
        ls_data = d;
        if (ls_valid) begin
            ls_valid = 1'b0;
            @(posedge clk);
            #1;
            ls_data_valid = 1'b0;
            ls_data = ~d;
        end
    endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench for the debug event detect unit
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin failures++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb;
    import dbgevt_pkg::*;
    logic clk, rst, internal_dbg_mode, external_dbg_mode, wait_dbg_mode, dbg_exc_allow;
    logic insn_done_evt_en, branch_taken_evt_en, exc_evt_en, trap_evt_en;
    logic [3:0] instr_match_en, value_cmp_first_bytes, value_cmp_second_bytes;
    logic instr_range_lo_pair_en, instr_range_hi_pair_en, instr_range_lo_pair_toggle, instr_range_hi_pair_toggle;
    logic excl_load, excl_lo_in, excl_hi_in, data_range_en, data_range_excl;
    logic [31:0] instr_addr_compare_1, instr_addr_compare_2, instr_addr_compare_3, instr_addr_compare_4;
    logic data_cmp_first_read_en, data_cmp_first_write_en, data_cmp_second_read_en, data_cmp_second_write_en;
    logic [1:0] data_cmp_first_size, data_cmp_second_size, value_cmp_first_mode, value_cmp_second_mode;
    logic [31:0] data_addr_compare_1, data_addr_compare_2, data_value_compare_1, data_value_compare_2;
    logic insn_done, branch_taken, exc_noncrit, exc_crit, trap_hit, uncond_req, instr_valid;
    logic [31:0] instr_addr, effective_addr, ls_data;
    logic ls_valid, ls_store, ls_data_valid, irq_any, status_clr;
    logic [ST_WIDTH-1:0] status_clr_mask, debug_status;
    logic dbg_irq, core_halt, trap_no_prog_exc, instr_range_lo_pair_excl, instr_range_hi_pair_excl;
    int failures, num_checks, i;
    logic [31:0] pa [4];
    logic [7:0] hitmap;

    dbgevt_unit dut (.*);
    dbgevt_core_model core (.*);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic cfg_zero();
        {internal_dbg_mode, external_dbg_mode, wait_dbg_mode, insn_done_evt_en, branch_taken_evt_en} = '0;
        {exc_evt_en, trap_evt_en, instr_match_en, instr_range_lo_pair_en, instr_range_hi_pair_en} = '0;
        {instr_range_lo_pair_toggle, instr_range_hi_pair_toggle, excl_load, excl_lo_in, excl_hi_in} = '0;
        {data_cmp_first_read_en, data_cmp_first_write_en, data_cmp_second_read_en, data_cmp_second_write_en} = '0;
        {data_cmp_first_size, data_cmp_second_size, data_range_en, data_range_excl, status_clr} = '0;
        {value_cmp_first_mode, value_cmp_first_bytes, value_cmp_second_mode, value_cmp_second_bytes} = '0;
        {instr_addr_compare_1, instr_addr_compare_2, instr_addr_compare_3, instr_addr_compare_4} = '0;
        {data_addr_compare_1, data_addr_compare_2, data_value_compare_1, data_value_compare_2} = '0;
        status_clr_mask = '0;
        dbg_exc_allow = 1'b1;
        // Let a halted core see its mode drop before the next setup
        @(posedge clk);
        #1;
    endtask

    task automatic clr(input logic [ST_WIDTH-1:0] mask);
        @(posedge clk);
        #1;
        status_clr = 1'b1;
        status_clr_mask = mask;
        @(posedge clk);
        #1;
        status_clr = 1'b0;
    endtask

    // Clean flags, one event, then compare masked flags
    task automatic probe(input logic [3:0] k, input logic [31:0] a, input logic st, input logic [31:0] d,
                         input logic [ST_WIDTH-1:0] mask, input logic [ST_WIDTH-1:0] exp);
        clr('1);
        core.issue(k, a, st, d);
        `CHK("status", exp, debug_status & mask)
    endtask

    task automatic finish_test();
        $display("Checks made %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        finish_test();
    end

    initial begin
        rst = 1'b1;
        failures = 0;
        num_checks = 0;
        cfg_zero();
        // First of the eight reset cycles is spent inside cfg_zero
        repeat (7) @(posedge clk);
        #1;
        rst = 1'b0;
        probe(4'h5, 0, 0, 0, '1, 14'h0010);
        `CHK("no action", 2'h0, {core_halt, dbg_irq})
        clr(14'h0001);
        `CHK("clear", 14'h0010, debug_status)
        clr(14'h0010);
        `CHK("clear", 14'h0000, debug_status)
        $display("Test record done");
        internal_dbg_mode = 1'b1;
        probe(4'h5, 0, 0, 0, '1, 14'h0010);
        `CHK("internal", 2'h1, {core_halt, dbg_irq})
        external_dbg_mode = 1'b1;
        probe(4'h5, 0, 0, 0, '1, 14'h0010);
        `CHK("both", 2'h3, {core_halt, dbg_irq})
        cfg_zero();
        {external_dbg_mode, insn_done_evt_en} = 2'h3;
        probe(4'h0, 0, 0, 0, '1, 14'h0001);
        `CHK("external", 2'h2, {core_halt, dbg_irq})
        cfg_zero();
        wait_dbg_mode = 1'b1;
        probe(4'h5, 0, 0, 0, '1, 14'h0010);
        `CHK("wait halt", 1'b1, core_halt)
        core.issue(4'h8, 0, 0, 0);
        `CHK("wait resume", 1'b0, core_halt)
        $display("Test modes done");
        cfg_zero();
        {internal_dbg_mode, dbg_exc_allow, insn_done_evt_en, branch_taken_evt_en, exc_evt_en} = 5'h17;
        probe(4'h0, 0, 0, 0, 14'h0001, 14'h0000);
        probe(4'h1, 0, 0, 0, 14'h0002, 14'h0000);
        probe(4'h3, 0, 0, 0, 14'h0004, 14'h0000);
        probe(4'h2, 0, 0, 0, 14'h0804, 14'h0804);
        external_dbg_mode = 1'b1;
        probe(4'h3, 0, 0, 0, 14'h0004, 14'h0004);
        cfg_zero();
        external_dbg_mode = 1'b1;
        probe(4'h4, 0, 0, 0, 14'h0008, 14'h0000);
        `CHK("trap off", 1'b0, trap_no_prog_exc)
        trap_evt_en = 1'b1;
        probe(4'h4, 0, 0, 0, 14'h0008, 14'h0008);
        `CHK("trap on", 1'b1, trap_no_prog_exc)
        @(posedge clk);
        #1;
        `CHK("trap pulse", 1'b0, trap_no_prog_exc)
        $display("Test events done");
        cfg_zero();
        instr_match_en = 4'h9;
        instr_addr_compare_1 = 32'h100;
        instr_addr_compare_4 = 32'h400;
        probe(4'h6, 32'h104, 0, 0, '1, 14'h0000);
        probe(4'h6, 32'h100, 0, 0, '1, 14'h0020);
        probe(4'h6, 32'h400, 0, 0, '1, 14'h2000);
        {instr_match_en, instr_range_lo_pair_en} = 5'h7;
        instr_addr_compare_1 = 32'h200;
        instr_addr_compare_2 = 32'h300;
        pa = '{32'h1FC, 32'h200, 32'h2FC, 32'h300};
        hitmap = 8'h96;
        for (i = 0; i < 8; i++) begin
            if (i == 4) begin
                {excl_lo_in, excl_load} = 2'h3;
                @(posedge clk);
                #1;
                excl_load = 1'b0;
            end
            probe(4'h6, pa[i % 4], 0, 0, 14'h0060, hitmap[i] ? 14'h0060 : 14'h0000);
        end
        instr_range_lo_pair_toggle = 1'b1;
        probe(4'h6, 32'h100, 0, 0, 14'h0060, 14'h0060);
        `CHK("toggle", 1'b0, instr_range_lo_pair_excl)
        {internal_dbg_mode, dbg_exc_allow} = 2'h2;
        probe(4'h6, 32'h200, 0, 0, 14'h0060, 14'h0000);
        cfg_zero();
        {instr_match_en, instr_range_hi_pair_en, instr_range_hi_pair_toggle} = 6'h33;
        instr_addr_compare_3 = 32'h500;
        instr_addr_compare_4 = 32'h600;
        probe(4'h6, 32'h5FC, 0, 0, 14'h3000, 14'h3000);
        `CHK("toggle hi", 1'b1, instr_range_hi_pair_excl)
        probe(4'h6, 32'h5FC, 0, 0, 14'h3000, 14'h0000);
        $display("Test instruction compare done");
        cfg_zero();
        data_cmp_first_read_en = 1'b1;
        data_addr_compare_1 = 32'h1000;
        pa = '{32'h0, 32'h1, 32'h3, 32'h1F};
        for (i = 0; i < 4; i++) begin
            data_cmp_first_size = 2'(i);
            probe(4'h7, 32'h1000 + pa[i], 0, 0, 14'h0780, 14'h0080);
            probe(4'h7, 32'h1001 + pa[i], 0, 0, 14'h0780, 14'h0000);
        end
        probe(4'h7, 32'h1000, 1, 0, 14'h0780, 14'h0000);
        data_cmp_second_write_en = 1'b1;
        data_addr_compare_2 = 32'h1800;
        probe(4'h7, 32'h1800, 1, 0, 14'h0780, 14'h0400);
        cfg_zero();
        {data_range_en, data_cmp_first_read_en, data_cmp_first_size} = 4'hF;
        data_addr_compare_1 = 32'h2000;
        data_addr_compare_2 = 32'h2010;
        pa = '{32'h1FFF, 32'h2000, 32'h200F, 32'h2010};
        for (i = 0; i < 4; i++) begin
            probe(4'h7, pa[i], 0, 0, 14'h0780, (i == 1 || i == 2) ? 14'h0080 : 14'h0000);
        end
        cfg_zero();
        data_cmp_first_read_en = 1'b1;
        data_addr_compare_1 = 32'h3000;
        {value_cmp_first_mode, value_cmp_first_bytes} = {VM_AND, 4'hF};
        data_value_compare_1 = 32'hCAFE1234;
        probe(4'h7, 32'h3000, 0, 32'hCAFE1234, 14'h0780, 14'h0080);
        probe(4'h7, 32'h3000, 0, 32'hCAFE1235, 14'h0780, 14'h0000);
        {value_cmp_first_mode, value_cmp_first_bytes} = {VM_OR, 4'h3};
        probe(4'h7, 32'h3000, 0, 32'h00001200, 14'h0780, 14'h0080);
        {value_cmp_first_mode, value_cmp_first_bytes} = {VM_ANDOR, 4'hF};
        probe(4'h7, 32'h3000, 0, 32'hCAFE0000, 14'h0780, 14'h0080);
        probe(4'h7, 32'h3000, 0, 32'hCA000034, 14'h0780, 14'h0000);
        $display("Test data compare done");
        finish_test();
    end
endmodule
